// ---- rlps_consts.svh ----
// Behaviour
// R01: Hold 16-bit destination address; match peers only
// R02: Foreign-address packets tracked, never output serially
// R03: Command-mode echo when enabled; off by default
// R04: Saturating failed-packet counter, cleared by reset
// R05: Saturating 16-bit good-packet counter, cleared by reset
// R06: Sleep transitions never clear receive counters
// R07: Force command prepends wake-up burst next transmission
// R08: Optional XON 0x11 / XOFF 0x13 flow control
// R09: General output pin drives CTS to host
// R10: Threshold reached asserts CTS stop or XOFF
// R11: Streaming initializer only first; periodic forced resync
// R12: Buffer drained gap forces initializer next transmission
// R13: Hop channel 0 to 9, default 0
// R14: Idle time triggers wake-up burst; 0xFFFF disables
// R15: Cyclic sleep listens per interval, stays on burst
// R16: Host keeps idle time below receiver sleep timeout
// R17: Matching 16-bit network tag; upper half factory-only
// R18: Write-only 256-bit key; zero key disables encryption
// R19: Encrypted payload, CRC on ciphertext, 16-byte IV
// R20: Fresh random IV per packet, chained mode
// R21: Key mismatch still outputs undecoded bytes
// R22: Read-only 16-bit hardware revision
// R23: Host enters command mode with guard-time sequence
// R24: Counters step exactly one, never wrap
`ifndef RLPS_CONSTS_SVH
`define RLPS_CONSTS_SVH
`define RLPS_OFF_DEST      8'h00
`define RLPS_OFF_IDLE      8'h03
`define RLPS_OFF_XONOFF    8'h07
`define RLPS_CMD_ECHO_OFF  8'h0a
`define RLPS_CMD_ECHO_ON   8'h0b
`define RLPS_CMD_FORCE_WK  8'h0d
`define RLPS_OFF_FAIL      8'h0f
`define RLPS_OFF_GOOD      8'h10
`define RLPS_OFF_HOP       8'h11
`define RLPS_OFF_FLOW      8'h24
`define RLPS_OFF_TAG       8'h27
`define RLPS_OFF_KEY       8'h3c
`define RLPS_OFF_SYNC      8'h3e
`define RLPS_OFF_HWREV     8'h50
`define RLPS_RST_DEST      16'h0000
`define RLPS_RST_IDLE      16'hffff
`define RLPS_IDLE_OFF      16'hffff
`define RLPS_RST_SYNC      16'h0000
`define RLPS_CNT_MAX       16'hffff
`define RLPS_HOP_MAX       8'h09
`define RLPS_TAG_FACTORY   16'h8000
`define RLPS_XON           8'h11
`define RLPS_XOFF          8'h13
`define RLPS_FLOW_MARGIN   17
`define RLPS_CLK_NS        25
`define RLPS_TICK_MS       10
`define RLPS_IDLE_UNIT_MS  100
`define RLPS_TICK_CYC      (`RLPS_TICK_MS * 1000000 / `RLPS_CLK_NS)
`define RLPS_IDLE_TICKS    (`RLPS_IDLE_UNIT_MS / `RLPS_TICK_MS)
`define RLPS_LISTEN_TICKS  4
`endif

// ---- rlps_core.sv ----
`include "rlps_consts.svh"
`default_nettype none
module rlps_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic [$clog2(D+1)-1:0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic          push;
  logic          pop;
  assign in_ready  = (level != D[$clog2(D+1)-1:0]);
  assign out_valid = (level != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rp];
  always_ff @(posedge clock) begin
    if (push) mem[wp] <= in_data;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wp    <= '0;
      rp    <= '0;
      level <= '0;
    end else begin
      if (push) wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
      if (pop) rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
      level <= level + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end
endmodule : rlps_fifo

module rlps_core #(
  parameter int          BUF_DEPTH = 4,
  parameter int          TICK_CYC  = `RLPS_TICK_CYC,
  parameter logic [15:0] TAG_RESET = 16'h1234,  // Arbitrary value
  parameter logic [15:0] HW_REV    = 16'h0a5a   // Arbitrary value
) (
  input  wire logic         clock,
  input  wire logic         rst,
  // Host command port
  input  wire logic         cmd_valid,
  input  wire logic         cmd_write,
  input  wire logic [7:0]   cmd_addr,
  input  wire logic [15:0]  cmd_wdata,
  output logic              rsp_valid,
  output logic [15:0]       rsp_rdata,
  // Host serial data
  input  wire logic         cmd_mode,
  input  wire logic         din_valid,
  output logic              din_ready,
  input  wire logic [7:0]   din_data,
  output logic              dout_valid,
  input  wire logic         dout_ready,
  output logic [7:0]        dout_data,
  output logic              flow_out_pin,
  // Radio transmit side
  output logic              tx_sof,
  output logic              tx_wakeup,
  output logic              tx_init,
  output logic              tx_encrypt,
  output logic [127:0]      tx_iv,
  output logic [255:0]      aes_key,
  output logic              tx_valid,
  input  wire logic         tx_ready,
  output logic [7:0]        tx_data,
  output logic [7:0]        hop_channel,
  output logic [15:0]       network_tag,
  // Radio receive side
  input  wire logic         rx_sop,
  input  wire logic [15:0]  rx_dest,
  input  wire logic [15:0]  rx_tag,
  input  wire logic [7:0]   rx_chan,
  input  wire logic         rx_valid,
  output logic              rx_ready,
  input  wire logic [7:0]   rx_data,
  input  wire logic         rx_good,
  input  wire logic         rx_fail,
  // Cyclic sleep
  input  wire logic         sleep_active,
  input  wire logic         sleep_wake_tick,
  input  wire logic         rx_burst_seen,
  output logic              rx_awake
);
  localparam int LW = $clog2(BUF_DEPTH + 1);
  localparam logic [15:0] FLOW_RST =
    (BUF_DEPTH > `RLPS_FLOW_MARGIN) ? 16'(BUF_DEPTH - `RLPS_FLOW_MARGIN) : 16'h0001;

  logic [15:0]  destination_address;
  logic [15:0]  idle_before_wakeup_burst;
  logic         xon_xoff_enable;
  logic [15:0]  rx_fail_count;
  logic [15:0]  rx_good_count;
  logic [15:0]  flow_threshold;
  logic [15:0]  forced_sync_period;
  logic         echo_on;
  logic         wr;
  logic         rd;
  logic         force_wakeup_burst;

  assign wr = cmd_valid & cmd_write;
  assign rd = cmd_valid & ~cmd_write;
  assign force_wakeup_burst = wr & (cmd_addr == `RLPS_CMD_FORCE_WK);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      destination_address      <= `RLPS_RST_DEST;  // [R01]
      idle_before_wakeup_burst <= `RLPS_RST_IDLE;
      xon_xoff_enable          <= 1'b0;
      hop_channel              <= 8'h00;
      flow_threshold           <= FLOW_RST;
      network_tag              <= TAG_RESET;
      forced_sync_period       <= `RLPS_RST_SYNC;
      aes_key                  <= '0;
      echo_on                  <= 1'b0;  // [R03]
    end else if (wr) begin
      unique case (cmd_addr)
        `RLPS_OFF_DEST:     destination_address <= cmd_wdata;
        `RLPS_OFF_IDLE:     idle_before_wakeup_burst <= cmd_wdata;
        `RLPS_OFF_XONOFF:   xon_xoff_enable <= cmd_wdata[0];  // [R08]
        `RLPS_OFF_HOP: begin
          if (cmd_wdata <= 16'(`RLPS_HOP_MAX)) hop_channel <= cmd_wdata[7:0];  // [R13]
        end
        `RLPS_OFF_FLOW:     flow_threshold <= cmd_wdata;
        `RLPS_OFF_TAG: begin
          if (cmd_wdata < `RLPS_TAG_FACTORY) network_tag <= cmd_wdata;  // [R17]
        end
        // Key enters 16 bits per write, oldest word ends up most significant
        `RLPS_OFF_KEY:      aes_key <= {aes_key[239:0], cmd_wdata};  // [R18]
        `RLPS_OFF_SYNC:     forced_sync_period <= cmd_wdata;
        `RLPS_CMD_ECHO_OFF: echo_on <= 1'b0;  // [R03]
        `RLPS_CMD_ECHO_ON:  echo_on <= 1'b1;  // [R03]
        default: ;
      endcase
    end
  end

  // Read answer one cycle after the request; key never appears here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= rd;
      if (rd) begin
        unique case (cmd_addr)
          `RLPS_OFF_DEST:   rsp_rdata <= destination_address;
          `RLPS_OFF_IDLE:   rsp_rdata <= idle_before_wakeup_burst;
          `RLPS_OFF_XONOFF: rsp_rdata <= {15'h0000, xon_xoff_enable};
          `RLPS_OFF_FAIL:   rsp_rdata <= rx_fail_count;
          `RLPS_OFF_GOOD:   rsp_rdata <= rx_good_count;
          `RLPS_OFF_HOP:    rsp_rdata <= {8'h00, hop_channel};
          `RLPS_OFF_FLOW:   rsp_rdata <= flow_threshold;
          `RLPS_OFF_TAG:    rsp_rdata <= network_tag;
          `RLPS_OFF_SYNC:   rsp_rdata <= forced_sync_period;
          `RLPS_OFF_HWREV:  rsp_rdata <= HW_REV;  // [R22]
          default:          rsp_rdata <= 16'h0000;  // [R18]
        endcase
      end
    end
  end

  // Counters: a write loads, and a coincident event still counts on top
  // No sleep input reaches these registers [R06]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_fail_count <= 16'h0000;  // [R04]
      rx_good_count <= 16'h0000;  // [R05]
    end else begin
      if (wr && cmd_addr == `RLPS_OFF_FAIL)
        rx_fail_count <= cmd_wdata + 16'((rx_fail && cmd_wdata != `RLPS_CNT_MAX) ? 1 : 0);
      else if (rx_fail && rx_fail_count != `RLPS_CNT_MAX)
        rx_fail_count <= rx_fail_count + 16'h0001;  // [R04] [R24]
      if (wr && cmd_addr == `RLPS_OFF_GOOD)
        rx_good_count <= cmd_wdata + 16'((rx_good && cmd_wdata != `RLPS_CNT_MAX) ? 1 : 0);
      else if (rx_good && rx_good_count != `RLPS_CNT_MAX)
        rx_good_count <= rx_good_count + 16'h0001;  // [R05] [R24]
    end
  end

  // 10 ms tick divider
  logic [$clog2(TICK_CYC)-1:0] div_cnt;
  logic tick;
  assign tick = (div_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) div_cnt <= '0;
    else div_cnt <= tick ? '0 : div_cnt + 1'b1;
  end

  // Serial input buffer
  logic          f_in_valid;
  logic          f_in_ready;
  logic          f_out_valid;
  logic [7:0]    f_out_data;
  logic [LW-1:0] f_level;
  logic          echo_pend;
  logic [7:0]    echo_byte;
  assign f_in_valid = din_valid & ~cmd_mode;
  assign din_ready  = cmd_mode ? ~echo_pend : f_in_ready;
  rlps_fifo #(.W(8), .D(BUF_DEPTH)) rlps_fifo_i (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (din_data),
    .out_valid (f_out_valid),
    .out_ready (tx_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );
  assign tx_valid = f_out_valid;
  assign tx_data  = f_out_data;

  // Flow control
  logic stop;
  logic xoff_pend;
  logic xon_pend;
  assign stop = (16'(f_level) >= flow_threshold);  // [R10]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) flow_out_pin <= 1'b0;
    else flow_out_pin <= stop;  // [R09] [R10]
  end

  // Output byte register; flow bytes first, then echo, then radio data
  logic load;
  logic take_flow;
  logic take_echo;
  logic rx_match;
  logic rx_keep;
  assign load      = ~dout_valid | dout_ready;
  assign take_flow = load & (xoff_pend | xon_pend);
  assign take_echo = load & ~take_flow & echo_pend;
  // Matching packets pass even when the cipher key differs [R21]
  assign rx_match  = (rx_dest == destination_address) && (rx_tag == network_tag)
                     && (rx_chan == hop_channel);  // [R01] [R13] [R17]
  // Foreign packets are consumed at full rate to stay in step
  assign rx_ready  = ~rx_keep | (load & ~take_flow & ~echo_pend);  // [R02]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) rx_keep <= 1'b0;
    else if (rx_sop) rx_keep <= rx_match;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dout_valid <= 1'b0;
      dout_data  <= 8'h00;
    end else if (load) begin
      dout_valid <= take_flow | take_echo | (rx_valid & rx_keep);  // [R02]
      if (take_flow) dout_data <= xoff_pend ? `RLPS_XOFF : `RLPS_XON;  // [R08]
      else if (take_echo) dout_data <= echo_byte;
      else dout_data <= rx_data;
    end
  end

  logic stop_d;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stop_d    <= 1'b0;
      xoff_pend <= 1'b0;
      xon_pend  <= 1'b0;
    end else begin
      stop_d <= stop;
      if (xon_xoff_enable && stop && !stop_d) begin
        xoff_pend <= 1'b1;  // [R08] [R10]
        xon_pend  <= 1'b0;
      end else if (xon_xoff_enable && !stop && stop_d) begin
        xon_pend  <= 1'b1;
        xoff_pend <= 1'b0;
      end else if (take_flow) begin
        xoff_pend <= 1'b0;
        xon_pend  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      echo_pend <= 1'b0;
      echo_byte <= 8'h00;
    end else if (cmd_mode && echo_on && din_valid && !echo_pend) begin
      echo_pend <= 1'b1;  // [R03]
      echo_byte <= din_data;
    end else if (take_echo) begin
      echo_pend <= 1'b0;
    end
  end

  // Transmit packet framing
  rlps_pkg::rlps_tx_t tx_state;
  assign tx_sof = f_out_valid & (tx_state == rlps_pkg::RLPS_TX_IDLE);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) tx_state <= rlps_pkg::RLPS_TX_IDLE;
    else if (tx_sof) tx_state <= rlps_pkg::RLPS_TX_STREAM;
    else if (!f_out_valid) tx_state <= rlps_pkg::RLPS_TX_IDLE;
  end

  // Initializer request; a new request beats the clear at frame start
  logic [15:0] sync_cnt;
  logic        sync_hit;
  assign sync_hit = tick && forced_sync_period != 16'h0000
                    && tx_state == rlps_pkg::RLPS_TX_STREAM
                    && sync_cnt + 16'h0001 >= forced_sync_period;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) sync_cnt <= 16'h0000;
    else if (tx_state == rlps_pkg::RLPS_TX_IDLE || sync_hit) sync_cnt <= 16'h0000;
    else if (tick) sync_cnt <= sync_cnt + 16'h0001;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) tx_init <= 1'b1;  // [R11]
    else if (!f_out_valid || sync_hit) tx_init <= 1'b1;  // [R11] [R12]
    else if (tx_sof) tx_init <= 1'b0;  // [R11]
  end

  // Idle timer in 100 ms units for the wake-up burst
  logic        traffic;
  logic [3:0]  unit_ticks;
  logic [15:0] idle_units;
  logic        idle_hit;
  assign traffic  = f_in_valid | f_out_valid | rx_valid | rx_sop;
  assign idle_hit = idle_before_wakeup_burst != `RLPS_IDLE_OFF
                    && idle_units >= idle_before_wakeup_burst;  // [R14]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unit_ticks <= 4'h0;
      idle_units <= 16'h0000;
    end else if (traffic) begin
      unit_ticks <= 4'h0;
      idle_units <= 16'h0000;
    end else if (tick) begin
      if (unit_ticks == 4'(`RLPS_IDLE_TICKS - 1)) begin
        unit_ticks <= 4'h0;
        if (idle_units != `RLPS_CNT_MAX) idle_units <= idle_units + 16'h0001;
      end else begin
        unit_ticks <= unit_ticks + 4'h1;
      end
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) tx_wakeup <= 1'b0;
    else if (force_wakeup_burst || idle_hit) tx_wakeup <= 1'b1;  // [R07] [R14]
    else if (tx_sof) tx_wakeup <= 1'b0;
  end

  // Encryption: per-packet IV from a free-running LFSR
  logic [127:0] lfsr;
  assign tx_encrypt = |aes_key;  // [R18] [R19]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lfsr  <= 128'h1;
      tx_iv <= '0;
    end else begin
      lfsr <= {lfsr[126:0], lfsr[127] ^ lfsr[6] ^ lfsr[1] ^ lfsr[0]};
      if (tx_sof) tx_iv <= lfsr;  // [R19] [R20]
    end
  end

  // Cyclic sleep listener
  rlps_pkg::rlps_sleep_t slp;
  logic [2:0] listen_cnt;
  assign rx_awake = ~sleep_active | (slp != rlps_pkg::RLPS_DOZE);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slp        <= rlps_pkg::RLPS_DOZE;
      listen_cnt <= 3'h0;
    end else if (!sleep_active) begin
      slp <= rlps_pkg::RLPS_DOZE;
    end else begin
      unique case (slp)
        rlps_pkg::RLPS_DOZE: begin
          if (sleep_wake_tick) begin
            slp        <= rlps_pkg::RLPS_LISTEN;  // [R15]
            listen_cnt <= 3'h0;
          end
        end
        rlps_pkg::RLPS_LISTEN: begin
          if (rx_burst_seen) slp <= rlps_pkg::RLPS_AWAKE;  // [R15]
          else if (tick) begin
            if (listen_cnt == 3'(`RLPS_LISTEN_TICKS - 1)) slp <= rlps_pkg::RLPS_DOZE;
            else listen_cnt <= listen_cnt + 3'h1;
          end
        end
        rlps_pkg::RLPS_AWAKE: begin
          if (sleep_wake_tick && !traffic) slp <= rlps_pkg::RLPS_LISTEN;
        end
        default: slp <= rlps_pkg::RLPS_DOZE;
      endcase
    end
  end
endmodule : rlps_core
`default_nettype wire

// ---- rlps_core_properties.sv ----
`default_nettype none
module rlps_core_properties #(
  parameter logic [15:0] HW_REV = 16'h0000
) (
  input wire logic         clock,
  input wire logic         rst,
  input wire logic         cmd_valid,
  input wire logic         cmd_write,
  input wire logic [7:0]   cmd_addr,
  input wire logic [15:0]  cmd_wdata,
  input wire logic         rsp_valid,
  input wire logic [15:0]  rsp_rdata,
  input wire logic         dout_valid,
  input wire logic         dout_ready,
  input wire logic [7:0]   dout_data,
  input wire logic         tx_sof,
  input wire logic         tx_wakeup,
  input wire logic         tx_encrypt,
  input wire logic [127:0] tx_iv,
  input wire logic [255:0] aes_key,
  input wire logic         tx_valid,
  input wire logic         tx_ready,
  input wire logic [7:0]   tx_data,
  input wire logic [7:0]   hop_channel,
  input wire logic [15:0]  network_tag,
  input wire logic         rx_awake
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic rd;
  logic wr;
  assign rd = cmd_valid && !cmd_write;
  assign wr = cmd_valid && cmd_write;
  a_read_answer: assert property (rd ##1 !rd |-> rsp_valid ##1 !rsp_valid)
    else $error("read answer not a single cycle after request");
  a_no_stray: assert property (!rd |=> !rsp_valid)
    else $error("response without a read");
  a_hw_rev: assert property (rd && cmd_addr == 8'h50 |=> rsp_rdata == HW_REV)
    else $error("hardware revision read wrong");
  a_key_hidden: assert property (rd && cmd_addr == 8'h3c |=> rsp_rdata == 16'h0000)
    else $error("key readable");
  a_key_enable: assert property (wr && cmd_addr == 8'h3c && cmd_wdata != 16'h0000
    |=> tx_encrypt)
    else $error("nonzero key did not enable encryption");
  a_iv_fresh: assert property (tx_sof |=> tx_iv != $past(tx_iv))
    else $error("packet reused the previous IV");
  a_hop_keep: assert property (wr && cmd_addr == 8'h11 && cmd_wdata > 16'h0009
    |=> $stable(hop_channel))
    else $error("hop channel took out of range value");
  a_hop_load: assert property (wr && cmd_addr == 8'h11 && cmd_wdata <= 16'h0009
    |=> $past(cmd_wdata) == {8'h00, hop_channel})
    else $error("hop channel not loaded");
  a_tag_keep: assert property (wr && cmd_addr == 8'h27 && cmd_wdata[15]
    |=> $stable(network_tag))
    else $error("factory tag range written");
  a_tag_load: assert property (wr && cmd_addr == 8'h27 && !cmd_wdata[15]
    |=> network_tag == $past(cmd_wdata))
    else $error("network tag not loaded");
  a_wake_force: assert property (wr && cmd_addr == 8'h0d |=> tx_wakeup)
    else $error("forced wake-up not armed");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("radio byte dropped while stalled");
  a_dout_hold: assert property (dout_valid && !dout_ready |=> dout_valid && $stable(dout_data))
    else $error("host byte dropped while stalled");
  c_wake_sent: cover property (tx_sof && tx_wakeup);
  c_xoff_sent: cover property (dout_valid && dout_data == 8'h13);
  c_rx_awake: cover property (!rx_awake ##1 rx_awake);
  c_rev_read: cover property (rsp_valid && rsp_rdata == HW_REV);
endmodule : rlps_core_properties
bind rlps_core rlps_core_properties #(.HW_REV(HW_REV)) rlps_core_properties_i (.*);
`default_nettype wire

// ---- rlps_host.sv ----
`default_nettype none
module rlps_host (
  input  wire logic        clock,
  output logic             cmd_valid = 1'b0,
  output logic             cmd_write = 1'b0,
  output logic [7:0]       cmd_addr = 8'h00,
  output logic [15:0]      cmd_wdata = 16'h0000,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_rdata,
  output logic             cmd_mode = 1'b0,
  output logic             din_valid = 1'b0,
  input  wire logic        din_ready,
  output logic [7:0]       din_data = 8'h00,
  input  wire logic        dout_valid,
  output logic             dout_ready,
  input  wire logic [7:0]  dout_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       stall = 1'b0;
  logic [7:0] got[$];
  assign dout_ready = !stall;
  always @(posedge clock)
    if (dout_valid && dout_ready)
      got.push_back(dout_data);
  // Guard-time sequence is detected upstream; only the level reaches the port
  task automatic mode(input logic m);
    @(posedge clock);
    #1;
    cmd_mode = m;
  endtask : mode
  task automatic cmd(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] q, output logic ok);
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr  = a;
    cmd_wdata = d;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    // Released bus shows a changed value so stale data cannot pass
    cmd_addr  = ~a;
    cmd_wdata = ~d;
    ok = w || rsp_valid === 1'b1;
    q = rsp_rdata;
  endtask : cmd
  task automatic put(input logic [7:0] b, output logic ok);
    int n = 0;
    @(posedge clock);
    #1;
    din_valid = 1'b1;
    din_data  = b;
    while (din_ready !== 1'b1 && n < 64) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    #1;
    din_valid = 1'b0;
    din_data  = ~b;
    ok = n < 64;
  endtask : put
endmodule : rlps_host
`default_nettype wire

// ---- rlps_pkg.sv ----
`default_nettype none
package rlps_pkg;
  typedef enum logic [1:0] {
    RLPS_DOZE   = 2'b00,
    RLPS_LISTEN = 2'b01,
    RLPS_AWAKE  = 2'b10
  } rlps_sleep_t;
  typedef enum logic {
    RLPS_TX_IDLE   = 1'b0,
    RLPS_TX_STREAM = 1'b1
  } rlps_tx_t;
endpackage : rlps_pkg
`default_nettype wire

// ---- test_radio_link_parameter_set.sv ----
`default_nettype none
module test_radio_link_parameter_set;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] TAG0 = 16'h2345;  // Arbitrary value
  localparam logic [15:0] REV  = 16'h0c3c;  // Arbitrary value
  logic         clock = 1'b0;
  logic         rst = 1'b1;
  logic         tx_ready = 1'b0;
  logic         rx_sop = 1'b0;
  logic         rx_valid = 1'b0;
  logic         rx_good = 1'b0;
  logic         rx_fail = 1'b0;
  logic         sleep_active = 1'b0;
  logic         sleep_wake_tick = 1'b0;
  logic         rx_burst_seen = 1'b0;
  logic [15:0]  rx_dest = 16'h0000;
  logic [15:0]  rx_tag = 16'h7fff;
  logic [7:0]   rx_chan = 8'h09;
  logic [7:0]   rx_data = 8'h00;
  logic         cmd_valid, cmd_write, cmd_mode, rsp_valid, din_valid, din_ready;
  logic         dout_valid, dout_ready, flow_out_pin, tx_sof, tx_wakeup, tx_init;
  logic         tx_encrypt, tx_valid, rx_ready, rx_awake, ok, sof_wake, sof_init;
  logic [7:0]   cmd_addr, din_data, dout_data, tx_data, hop_channel, a;
  logic [15:0]  cmd_wdata, rsp_rdata, network_tag;
  logic [127:0] tx_iv;
  logic [255:0] aes_key;
  logic [7:0]   txq[$];
  int           fail_count = 0;
  int           n_checks = 0;
  logic [7:0]   ra[12] = '{8'h00, 8'h03, 8'h07, 8'h0f, 8'h10, 8'h11,
                           8'h24, 8'h27, 8'h3e, 8'h50, 8'h3c, 8'h55};
  logic [15:0]  rv[12] = '{16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                           16'h0001, TAG0, 16'h0000, REV, 16'h0000, 16'h0000};
  rlps_core #(.BUF_DEPTH(4), .TICK_CYC(10), .TAG_RESET(TAG0), .HW_REV(REV)) rlps_core_i (.*);
  rlps_host rlps_host_i (.*);
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (tx_sof) begin
      sof_wake <= tx_wakeup;
      sof_init <= tx_init;
    end
    if (tx_valid && tx_ready)
      txq.push_back(tx_data);
  end
  task automatic chk(input logic [255:0] g, input logic [255:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %0h expected %0h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    logic [15:0] q;
    rlps_host_i.cmd(1'b1, ad, d, q, ok);
  endtask : wr
  task automatic rdc(input logic [7:0] ad, input logic [15:0] e);
    logic [15:0] q;
    rlps_host_i.cmd(1'b0, ad, 16'h0000, q, ok);
    chk(ok, 1'b1);
    chk(q, e);
  endtask : rdc
  task automatic wait_n(input int k, input logic tx);
    int n = 0;
    while ((tx ? txq.size() : rlps_host_i.got.size()) < k && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(n < 100, 1'b1);
  endtask : wait_n
  task automatic pulse(ref logic s, input int k);
    repeat (k) begin
      @(posedge clock);
      #1;
      s = 1'b1;
      @(posedge clock);
      #1;
      s = 1'b0;
    end
  endtask : pulse
  task automatic bump(input int i, input int k);
    if (i == 0)
      pulse(rx_good, k);
    else
      pulse(rx_fail, k);
  endtask : bump
  task automatic rx_pkt(input logic [15:0] d, input logic [7:0] b);
    int n = 0;
    @(posedge clock);
    #1;
    rx_sop = 1'b1;
    rx_dest = d;
    @(posedge clock);
    #1;
    rx_sop = 1'b0;
    rx_valid = 1'b1;
    rx_data = b;
    while (rx_ready !== 1'b1 && n < 64) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    #1;
    rx_valid = 1'b0;
    rx_data = ~b;
    rx_dest = ~d;
    chk(n < 64, 1'b1);
  endtask : rx_pkt
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    chk(tx_init, 1'b1);
    chk(flow_out_pin, 1'b0);
    for (int i = 0; i < 12; i++) rdc(ra[i], rv[i]);
    wr(8'h00, 16'hbeef);
    rdc(8'h00, 16'hbeef);
    wr(8'h11, 16'h0009);
    wr(8'h11, 16'h000a);
    rdc(8'h11, 16'h0009);
    wr(8'h27, 16'h7fff);
    wr(8'h27, 16'h8000);
    rdc(8'h27, 16'h7fff);
    wr(8'h50, 16'h0000);
    rdc(8'h50, REV);
    for (int i = 0; i < 2; i++) begin
      a = (i == 0) ? 8'h10 : 8'h0f;
      bump(i, 3);
      sleep_active = 1'b1;
      pulse(sleep_wake_tick, 1);
      pulse(rx_burst_seen, 1);
      chk(rx_awake, 1'b1);
      sleep_active = 1'b0;
      rdc(a, 16'h0003);
      wr(a, 16'hfffe);
      bump(i, 3);
      rdc(a, 16'hffff);
      wr(a, 16'h0005);
      rdc(a, 16'h0005);
    end
    for (int i = 0; i < 16; i++) wr(8'h3c, 16'(i + 1));
    chk(aes_key[255:240], 16'h0001);
    chk(aes_key[15:0], 16'h0010);
    chk(tx_encrypt, 1'b1);
    rdc(8'h3c, 16'h0000);
    for (int i = 0; i < 16; i++) wr(8'h3c, 16'h0000);
    chk(tx_encrypt, 1'b0);
    rlps_host_i.mode(1'b1);
    rlps_host_i.put(8'h41, ok);
    repeat (8) @(posedge clock);
    chk(rlps_host_i.got.size(), 0);
    wr(8'h0b, 16'h0000);
    rlps_host_i.put(8'h42, ok);
    wait_n(1, 1'b0);
    chk(rlps_host_i.got[0], 8'h42);
    wr(8'h0a, 16'h0000);
    rlps_host_i.put(8'h43, ok);
    repeat (8) @(posedge clock);
    chk(rlps_host_i.got.size(), 1);
    // Host stalls so the stop byte must wait its turn
    rlps_host_i.mode(1'b0);
    rlps_host_i.got.delete();
    rlps_host_i.stall = 1'b1;
    wr(8'h07, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      rlps_host_i.put(8'ha0 + 8'(i), ok);
      chk(ok, 1'b1);
    end
    chk(din_ready, 1'b0);
    chk(flow_out_pin, 1'b1);
    chk(sof_init, 1'b1);
    chk(sof_wake, 1'b0);
    chk(tx_init, 1'b0);
    rlps_host_i.stall = 1'b0;
    wait_n(1, 1'b0);
    chk(rlps_host_i.got[0], 8'h13);
    tx_ready = 1'b1;
    wait_n(4, 1'b1);
    for (int i = 0; i < 4; i++) chk(txq[i], 8'ha0 + 8'(i));
    wr(8'h0d, 16'h0000);
    rlps_host_i.put(8'hb5, ok);
    wait_n(5, 1'b1);
    chk(sof_wake, 1'b1);
    chk(sof_init, 1'b1);
    chk(tx_wakeup, 1'b0);
    // Radio stalled so the stream stays open until the sync period forces a new initializer
    wr(8'h3e, 16'h0001);
    tx_ready = 1'b0;
    rlps_host_i.put(8'hc6, ok);
    repeat (30) @(posedge clock);
    #1;
    chk(tx_init, 1'b1);
    tx_ready = 1'b1;
    wr(8'h03, 16'h0001);
    repeat (150) @(posedge clock);
    chk(tx_wakeup, 1'b1);
    rlps_host_i.got.delete();
    rx_pkt(16'h1111, 8'h5a);
    rx_pkt(16'hbeef, 8'h6b);
    wait_n(1, 1'b0);
    chk(rlps_host_i.got[0], 8'h6b);
    chk(rlps_host_i.got.size(), 1);
    print_verdict();
  end
endmodule : test_radio_link_parameter_set
`default_nettype wire
